// ==== common/stt_pkg.sv ====
// Constants for the supervisory timeout timer: register map, fields, timing.
// Assumes a 20 MHz system clock and one configuration register.
package stt_pkg;
	// Register offset of the watchdog configuration register
	localparam logic [7:0] STT_CFG_OFFSET = 8'h17;
	// Field positions inside the configuration register
	localparam int STT_RSVD_HI = 7;
	localparam int STT_RSVD_LO = 6;
	localparam int STT_PER_HI = 5;
	localparam int STT_PER_LO = 4;
	localparam int STT_ACTION_BIT = 3;
	localparam int STT_FEED_BIT = 2;
	localparam int STT_ON_BIT = 1;
	localparam int STT_GUARD_BIT = 0;
	// Reset values of the software fields
	localparam logic [1:0] STT_PER_RESET = 2'h3;
	localparam logic STT_ACTION_RESET = 1'b0;
	// Timeout interval for each period code, in seconds
	localparam logic [7:0] STT_SEC_CODE0 = 8'h10;
	localparam logic [7:0] STT_SEC_CODE1 = 8'h20;
	localparam logic [7:0] STT_SEC_CODE2 = 8'h40;
	localparam logic [7:0] STT_SEC_CODE3 = 8'h80;
	// One second tick derived from the system clock
	localparam int STT_CLK_HZ = 20000000;
	localparam int STT_TICK_S = 1;
	localparam int STT_TICK_CYCLES = STT_CLK_HZ * STT_TICK_S;
	localparam int STT_TICK_W = 25;
	// Expiry action encodings
	localparam logic STT_ACT_POWER_OFF = 1'b0;
	localparam logic STT_ACT_POWER_RESET = 1'b1;
endpackage

// ==== rtl/stt_watchdog.sv ====
// Supervisory timeout timer with its configuration register.
// Assumes a simple synchronous register port driven by the serial
// interface logic, and factory settings presented as steady levels.
`timescale 1ns/1ns

// How it works
// - Period code selects 16, 32, 64 or 128 s
// - Changing period code reloads the countdown one cycle after the write
// - Expiry powers off, or resets when action set
// - Software feeds before timeout; feed reloads fully
// - Writing zero to feed changes nothing
// - Enabled timer counts and expires; disabled idles
// - Guard set: enable cannot be cleared, only set
// - Guard is read-only, loaded from factory setting
// - Reserved bits written zero; read as zero
module stt_watchdog import stt_pkg::*; #(
	parameter int TICK_CYCLES = STT_TICK_CYCLES
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic otp_timer_on_in,
	input wire logic otp_disable_guard_in,
	output logic [7:0] reg_rdata_out,
	output logic power_off_out,
	output logic power_reset_out
);

	////////////////////////////////////////////////////////////////////
	// Helpers

	// Timeout interval in seconds for a period code
	function automatic logic [7:0] timeout_interval(input logic [1:0] sel);
		unique case (sel)
			2'h0: timeout_interval = STT_SEC_CODE0;
			2'h1: timeout_interval = STT_SEC_CODE1;
			2'h2: timeout_interval = STT_SEC_CODE2;
			2'h3: timeout_interval = STT_SEC_CODE3;
		endcase
	endfunction

	localparam logic [STT_TICK_W-1:0] TICK_LAST =
		STT_TICK_W'(TICK_CYCLES - 1);

	////////////////////////////////////////////////////////////////////
	// Register state

	logic [1:0] timeout_period_sel_ff; // Period code
	logic expire_action_sel_ff; // Action on expiry
	logic timer_on_ff; // Timer enable
	logic disable_guard_ff; // Factory guard, read only
	logic feed_strobe_ff; // One-cycle feed request
	logic per_change_ff; // One-cycle period change request
	logic [7:0] sec_left_ff; // Seconds remaining
	logic [STT_TICK_W-1:0] tick_cnt_ff; // Sub-second prescaler
	logic [7:0] reg_rdata_ff;
	logic power_off_ff;
	logic power_reset_ff;

	logic cfg_wr; // Write hits the configuration register
	logic nxt_timer_on;
	logic tick; // Last cycle of a second
	logic expire; // Countdown ends this cycle

	assign cfg_wr = reg_wr_in && (reg_addr_in == STT_CFG_OFFSET);
	assign tick = (tick_cnt_ff == TICK_LAST);
	assign expire = timer_on_ff && tick && (sec_left_ff == 8'h01);

	// Guard only blocks clearing the enable, setting always works
	always_comb begin
		if (disable_guard_ff) begin
			nxt_timer_on = timer_on_ff | reg_wdata_in[STT_ON_BIT];
		end else begin
			nxt_timer_on = reg_wdata_in[STT_ON_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Configuration register writes

	// Reserved bits are not stored; software is expected to write zero
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			timeout_period_sel_ff <= STT_PER_RESET;
			expire_action_sel_ff <= STT_ACTION_RESET;
		end else if (cfg_wr) begin
			timeout_period_sel_ff <= reg_wdata_in[STT_PER_HI:STT_PER_LO];
			expire_action_sel_ff <= reg_wdata_in[STT_ACTION_BIT];
		end
	end

	// Enable and guard come from factory levels, sampled during reset
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			timer_on_ff <= otp_timer_on_in;
			disable_guard_ff <= otp_disable_guard_in;
		end else if (cfg_wr) begin
			timer_on_ff <= nxt_timer_on;
		end
	end

	// Feed and period change become one-cycle requests
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			feed_strobe_ff <= 1'b0;
			per_change_ff <= 1'b0;
		end else begin
			// A written zero raises no request
			feed_strobe_ff <= cfg_wr && reg_wdata_in[STT_FEED_BIT];
			per_change_ff <= cfg_wr && (reg_wdata_in[STT_PER_HI:STT_PER_LO]
				!= timeout_period_sel_ff);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Countdown

	// Prescaler makes the one-second tick; restarts on any reload
	always_ff @(posedge sys_clk_in) begin
		if (reset_in || !timer_on_ff || feed_strobe_ff || per_change_ff) begin
			tick_cnt_ff <= '0;
		end else if (tick) begin
			tick_cnt_ff <= '0;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 1'b1;
		end
	end

	// Seconds counter; a reload wins over a tick in the same cycle
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			sec_left_ff <= timeout_interval(STT_PER_RESET);
		end else if (!timer_on_ff) begin
			sec_left_ff <= timeout_interval(timeout_period_sel_ff);
		end else if (feed_strobe_ff || per_change_ff) begin
			sec_left_ff <= timeout_interval(timeout_period_sel_ff);
		end else if (expire) begin
			// Restart so a power reset leaves a running supervisor
			sec_left_ff <= timeout_interval(timeout_period_sel_ff);
		end else if (tick) begin
			sec_left_ff <= sec_left_ff - 8'h01;
		end
	end

	// Expiry action pulses, one cycle each
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			power_off_ff <= 1'b0;
			power_reset_ff <= 1'b0;
		end else begin
			power_off_ff <= expire &&
				(expire_action_sel_ff == STT_ACT_POWER_OFF);
			power_reset_ff <= expire &&
				(expire_action_sel_ff == STT_ACT_POWER_RESET);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read back

	// Registered read, one cycle after the address; other offsets read 0
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			reg_rdata_ff <= 8'h00;
		end else if (reg_addr_in == STT_CFG_OFFSET) begin
			// Feed always reads zero since it is a strobe
			reg_rdata_ff <= {2'h0, timeout_period_sel_ff,
				expire_action_sel_ff, 1'b0, timer_on_ff, disable_guard_ff};
		end else begin
			reg_rdata_ff <= 8'h00;
		end
	end

	assign reg_rdata_out = reg_rdata_ff;
	assign power_off_out = power_off_ff;
	assign power_reset_out = power_reset_ff;

	////////////////////////////////////////////////////////////////////
	// Checks

	AST_PERIOD_RELOAD: assert property (@(posedge sys_clk_in)
		disable iff (reset_in)
		cfg_wr && reg_wdata_in[STT_ON_BIT] && !reg_wdata_in[STT_FEED_BIT]
		&& (reg_wdata_in[STT_PER_HI:STT_PER_LO] != timeout_period_sel_ff)
		|=> ##1 sec_left_ff == timeout_interval(
			$past(reg_wdata_in[STT_PER_HI:STT_PER_LO], 2)))
		else $error("period change did not reload countdown");

	AST_PERIOD_MAP: assert property (@(posedge sys_clk_in)
		disable iff (reset_in)
		!timer_on_ff && !cfg_wr |=> sec_left_ff == (8'h10 <<
			$past(timeout_period_sel_ff)))
		else $error("timeout interval does not match period code");

	AST_FEED_RELOAD: assert property (@(posedge sys_clk_in)
		disable iff (reset_in)
		// Period seen at the reload edge; a write there may move it after
		feed_strobe_ff && timer_on_ff |=>
		sec_left_ff == timeout_interval($past(timeout_period_sel_ff))
		&& tick_cnt_ff == '0)
		else $error("feed did not reload full timeout");

	AST_FEED_ZERO: assert property (@(posedge sys_clk_in)
		disable iff (reset_in)
		timer_on_ff && !feed_strobe_ff && !per_change_ff && !tick
		|=> $stable(sec_left_ff))
		else $error("countdown moved without a tick");

	AST_OFF_ACTION: assert property (@(posedge sys_clk_in)
		disable iff (reset_in)
		expire && !expire_action_sel_ff |=> power_off_out && !power_reset_out)
		else $error("expiry with action 0 did not power off");

	AST_RESET_ACTION: assert property (@(posedge sys_clk_in)
		disable iff (reset_in)
		expire && expire_action_sel_ff |=> power_reset_out && !power_off_out)
		else $error("expiry with action 1 did not power reset");

	AST_GUARD_HOLD: assert property (@(posedge sys_clk_in)
		disable iff (reset_in)
		disable_guard_ff && timer_on_ff |=> timer_on_ff)
		else $error("guarded enable was cleared");

	AST_GUARD_FIXED: assert property (@(posedge sys_clk_in)
		disable iff (reset_in)
		##1 $stable(disable_guard_ff))
		else $error("guard bit changed after reset");

	AST_FEED_READS_ZERO: assert property (@(posedge sys_clk_in)
		disable iff (reset_in)
		// Without a fresh write the strobe must drop; feed never reads 1
		feed_strobe_ff && !cfg_wr |=> !feed_strobe_ff
		&& !reg_rdata_out[STT_FEED_BIT])
		else $error("feed strobe did not clear");

	AST_IDLE_NO_ACTION: assert property (@(posedge sys_clk_in)
		disable iff (reset_in)
		!timer_on_ff |=> !power_off_out && !power_reset_out)
		else $error("disabled timer produced an expiry");

	AST_RSVD_ZERO: assert property (@(posedge sys_clk_in)
		disable iff (reset_in)
		reg_rdata_out[7:6] == 2'h0)
		else $error("reserved bits read nonzero");

endmodule

// ==== dv/supervisory_timeout_timer_tb_top.sv ====
// Self-checking bench for the supervisory timeout timer register port.
// Assumes a short tick (TICK_CYCLES) so every timeout ends quickly.
`timescale 1ns/1ns
module supervisory_timeout_timer_tb_top import stt_pkg::*;;
	localparam int TC = 4; // Short tick keeps the run brief
	logic sys_clk_in; // 20 MHz bench clock
	logic reset_in, wr, otp_on, otp_guard; // Strobes and factory levels
	logic [7:0] addr, wdata, rdata, v; // Register port and readback
	logic po, pr, a; // Action pulses, chosen action
	logic [1:0] p; // Period code under test
	int cyc = 0; // Rising edges seen so far
	int t0, k, error_cnt, comparisons;

	stt_watchdog #(.TICK_CYCLES(TC)) dut (.sys_clk_in(sys_clk_in),
		.reset_in(reset_in), .reg_addr_in(addr), .reg_wr_in(wr),
		.reg_wdata_in(wdata), .otp_timer_on_in(otp_on),
		.otp_disable_guard_in(otp_guard), .reg_rdata_out(rdata),
		.power_off_out(po), .power_reset_out(pr));

	////////////////////////////////////////////////////////////////////
	// Clock and edge counter
	initial begin
		sys_clk_in = 1'b0;
		forever #25 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in) begin
		cyc <= cyc + 1;
	end

	////////////////////////////////////////////////////////////////////
	// Helpers: compare, verdict, reset, bus cycles
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task summarize;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Factory levels are only sampled while reset is high
	task rst(input logic on, input logic g);
		@(negedge sys_clk_in);
		reset_in = 1'b1;
		otp_on = on;
		otp_guard = g;
		repeat (16) @(negedge sys_clk_in);
		reset_in = 1'b0;
	endtask
	// One-cycle write; t0 holds the edge that took it
	task wr_reg(input logic [7:0] a8, input logic [7:0] d);
		@(negedge sys_clk_in);
		addr = a8;
		wdata = d;
		wr = 1'b1;
		@(negedge sys_clk_in);
		wr = 1'b0;
		t0 = cyc;
	endtask
	// Read data lags the address by one edge
	task rd(input logic [7:0] a8, output logic [7:0] d);
		@(negedge sys_clk_in);
		addr = a8;
		@(negedge sys_clk_in);
		d = rdata;
	endtask
	function logic [7:0] cfg(input logic [1:0] per, input logic [3:0] lo);
		return {2'h0, per, lo};
	endfunction
	function int tmo(input logic [1:0] per);
		return (16 << per) * TC;
	endfunction
	// Waits for the first pulse, checks its moment, kind and width
	task expire(input int from, input logic [1:0] per, input logic act);
		k = 0;
		while (po !== 1'b1 && pr !== 1'b1 && k < 2000) begin
			@(negedge sys_clk_in);
			k++;
		end
		chk(32'(cyc - from), 32'(tmo(per) + 1));
		chk(32'({po, pr}), 32'({~act, act}));
		@(negedge sys_clk_in);
		chk(32'({po, pr}), 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		reset_in = 1'b1;
		wr = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		otp_on = 1'b1;
		otp_guard = 1'b0;
		error_cnt = 0;
		comparisons = 0;
		void'($urandom(32'h8c06));
		rst(1'b1, 1'b0);
		rd(STT_CFG_OFFSET, v);
		chk(32'(v), 32'(cfg(2'h3, 4'h2)));
		$display("reset test done");
		// Every period code; starts from 11 so each pass's first write is a change
		for (int i = 0; i < 4; i++) begin
			p = 2'(i);
			a = 1'($urandom);
			wr_reg(STT_CFG_OFFSET, cfg(p, {a, 3'h2}));
			k = t0;
			repeat (2 + $urandom % (tmo(p) / 2)) @(negedge sys_clk_in);
			// Same value, feed clear: must not shift the expiry
			wr_reg(STT_CFG_OFFSET, cfg(p, {a, 3'h2}));
			t0 = k;
			expire(k, p, a);
			// Other action, so both expiry kinds are seen for every period
			a = ~a;
			repeat (2 + $urandom % 20) @(negedge sys_clk_in);
			wr_reg(STT_CFG_OFFSET, cfg(p, {a, 3'h6}));
			expire(t0, p, a);
			rd(STT_CFG_OFFSET, v);
			chk(32'(v), 32'(cfg(p, {a, 3'h2})));
			$display("period test %0d done", i);
		end
		// Unmapped address: no effect, reads zero
		wr_reg(8'h16, 8'h00);
		rd(STT_CFG_OFFSET, v);
		chk(32'(v), 32'(cfg(2'h3, {a, 3'h2})));
		rd(8'h16, v);
		chk(32'(v), 32'h0);
		// Disabled: longer than any timeout, no pulse at all
		wr_reg(STT_CFG_OFFSET, cfg(2'h0, 4'h0));
		k = 0;
		repeat (600) begin
			@(negedge sys_clk_in);
			if (po !== 1'b0 || pr !== 1'b0) k++;
		end
		chk(32'(k), 32'h0);
		$display("disable test done");
		// Guarded part: enable may be set but never cleared
		rst(1'b0, 1'b1);
		rd(STT_CFG_OFFSET, v);
		chk(32'(v), 32'(cfg(2'h3, 4'h1)));
		wr_reg(STT_CFG_OFFSET, cfg(2'h3, 4'h2));
		rd(STT_CFG_OFFSET, v);
		chk(32'(v), 32'(cfg(2'h3, 4'h3)));
		wr_reg(STT_CFG_OFFSET, cfg(2'h3, 4'h0));
		rd(STT_CFG_OFFSET, v);
		chk(32'(v), 32'(cfg(2'h3, 4'h3)));
		$display("guard test done");
		summarize;
	end

	////////////////////////////////////////////////////////////////////
	// Hang guard: well beyond the few thousand cycles the tests need
	initial begin
		#(50 * 12000);
		error_cnt++;
		summarize;
	end
endmodule
